// [core/dmom_pkg.sv]
package dmom_pkg;

	// clock and time base
	localparam int unsigned CLK_HZ  = 20_000_000;
	localparam int unsigned US_CYC  = CLK_HZ / 1_000_000;
	localparam logic [4:0]  US_LAST = 5'(US_CYC - 1);

	// measurement period limits and shortest speed windows in microseconds
	localparam logic [15:0] PER1_MIN_US = 16'h00FA;
	localparam logic [15:0] PER1_MAX_US = 16'h1644;
	localparam logic [15:0] SPD1_US     = 16'h01F4;
	localparam logic [15:0] SPD2_US     = 16'h02EE;

	// geometry limits
	localparam int unsigned MIN_SPAN_MM    = 4;
	localparam logic [23:0] MIN_SPAN_UM    = 24'(MIN_SPAN_MM * 1000);
	localparam logic [15:0] MIN_TWO_LEN_MM = 16'h005A;
	// 10 m/s equals 10 um per us
	localparam int unsigned SPD_MAX_MPS    = 10;
	localparam logic [23:0] SPD_UM_PER_US  = 24'(SPD_MAX_MPS);

	// register byte addresses
	localparam logic [5:0] A_CTRL   = 6'h00;
	localparam logic [5:0] A_NOMLEN = 6'h04;
	localparam logic [5:0] A_NULL [2] = '{6'h08, 6'h10};
	localparam logic [5:0] A_END  [2] = '{6'h0C, 6'h14};
	localparam logic [5:0] A_LIM  [2] = '{6'h18, 6'h1C};
	localparam logic [5:0] A_ERRV   = 6'h20;
	localparam logic [5:0] A_TEACH  = 6'h24;
	localparam logic [5:0] A_STAT   = 6'h28;
	localparam logic [5:0] A_OUT    = 6'h2C;

	// control field positions
	localparam int unsigned MODE_LSB = 0;
	localparam int unsigned FN_LSB   = 2;
	localparam int unsigned INV_LSB  = 8;
	localparam int unsigned COPY_LSB = 10;

	// magnet modes and output functions
	localparam logic [1:0] MODE_ONE  = 2'h1;
	localparam logic [1:0] MODE_TWO  = 2'h2;
	localparam logic [1:0] MODE_FLEX = 2'h3;
	localparam logic [2:0] FN_POS    = 3'h0;
	localparam logic [2:0] FN_SPD    = 3'h1;
	localparam logic [2:0] FN_SPDU   = 3'h2;
	localparam logic [2:0] FN_DIFF   = 3'h3;

	// reset values, output scale and last divider step
	localparam logic [15:0] NOMLEN_RST = 16'h01F4;
	localparam logic [23:0] END_RST_UM = 24'h07_A120;
	localparam logic [15:0] OUT_FS     = 16'h7FFF;
	localparam logic [15:0] LMIN_RST   = 16'h8000;
	localparam logic [15:0] LMAX_RST   = 16'h7FFF;
	localparam logic [15:0] ERRV_RST   = 16'h7FFF;
	localparam logic [5:0]  DIV_LAST   = 6'h27;

	// sample from the measuring front end, positions in um
	typedef struct packed {
		logic        valid;
		logic [1:0]  count;
		logic [23:0] pos1;
		logic [23:0] pos0;
	} dmom_fe_t;

	// output channel codes towards the output stage
	typedef struct packed {
		logic        strobe;
		logic [1:0]  err;
		logic [15:0] ch1;
		logic [15:0] ch0;
	} dmom_out_t;

	typedef enum logic [1:0] {D_IDLE, D_RUN, D_FIN} dmom_dstate_t;
endpackage : dmom_pkg

// [core/dmom_core.sv]
// The register addresses and the strobed register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module dmom_core (
	input  wire logic               mclk,
	input  wire logic               nrst,
	input  wire logic [5:0]         addr,
	input  wire logic [31:0]        wdata,
	input  wire logic               wr_stb,
	input  wire logic               rd_stb,
	output var  logic [31:0]        rdata,
	input  wire dmom_pkg::dmom_fe_t fe,
	output var  dmom_pkg::dmom_out_t ch_out
);

	// absolute difference of two positions
	function automatic logic [23:0] absd(input logic [23:0] a, input logic [23:0] b);
		return (a > b) ? a - b : b - a;
	endfunction : absd

	// null and end far enough apart
	function automatic logic span_ok(input logic [23:0] a, input logic [23:0] b);
		return absd(a, b) >= dmom_pkg::MIN_SPAN_UM;
	endfunction : span_ok

	// register write decode
	function automatic logic wr_hit(input logic [5:0] r);
		return wr_stb && (addr == r);
	endfunction : wr_hit

	dmom_pkg::dmom_fe_t samp_r;          // latest front-end sample
	logic [1:0]         mode_r;          // magnet mode
	logic [2:0]         func_r [2];      // function per channel
	logic [1:0]         inv_r;           // curve inversion per channel
	logic [15:0]        nomlen_r;        // nominal length in mm
	logic [23:0]        null_r [2];      // null point in um
	logic [23:0]        end_r  [2];      // end point in um
	logic [15:0]        lmin_r [2];      // lower output limit
	logic [15:0]        lmax_r [2];      // upper output limit
	logic [15:0]        errv_r [2];      // error value
	logic [2:0]         rej_r;           // sticky refusals
	logic [1:0]         mode_w;          // requested mode
	logic               mode_ok;         // requested mode accepted
	logic [1:0]         mode_eff;        // mode after this write
	logic [2:0]         fn_w   [2];      // requested functions
	logic [1:0]         fn_ok;           // requested function accepted
	logic [23:0]        tpos   [2];      // teach position per channel
	logic [1:0]         tdet;            // magnet present for teach
	logic [1:0]         null_ok;         // written null accepted
	logic [1:0]         end_ok;          // written end accepted
	logic [1:0]         tn_ok;           // taught null accepted
	logic [1:0]         te_ok;           // taught end accepted
	logic [2:0]         rej_set;         // refusal events

	// capture each front-end sample
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			samp_r <= '0;
		end else if (fe.valid) begin
			samp_r <= fe;
		end
	end

	// acceptance checks for configuration writes
	always_comb begin
		mode_w   = wdata[dmom_pkg::MODE_LSB +: 2];
		mode_ok  = (mode_w != 2'h0) &&
			!(mode_w == dmom_pkg::MODE_TWO && nomlen_r < dmom_pkg::MIN_TWO_LEN_MM);
		mode_eff = mode_ok ? mode_w : mode_r;
		rej_set  = '0;
		for (int i = 0; i < 2; i++) begin
			fn_w[i]    = wdata[dmom_pkg::FN_LSB + 3 * i +: 3];
			// spacing allowed only when two magnets are chosen
			fn_ok[i]   = (fn_w[i] <= dmom_pkg::FN_SPDU) ||
				(fn_w[i] == dmom_pkg::FN_DIFF && mode_eff == dmom_pkg::MODE_TWO);
			tpos[i]    = (i == 1 && mode_r != dmom_pkg::MODE_ONE) ? samp_r.pos1 : samp_r.pos0;
			tdet[i]    = (i == 1 && mode_r != dmom_pkg::MODE_ONE) ? samp_r.count >= 2'h2
				: samp_r.count != 2'h0;
			null_ok[i] = span_ok(wdata[23:0], end_r[i]);
			end_ok[i]  = span_ok(null_r[i], wdata[23:0]);
			tn_ok[i]   = tdet[i] && span_ok(tpos[i], end_r[i]);
			te_ok[i]   = tdet[i] && span_ok(null_r[i], tpos[i]);
			if ((wr_hit(dmom_pkg::A_NULL[i]) && !null_ok[i]) ||
				(wr_hit(dmom_pkg::A_END[i]) && !end_ok[i]) ||
				(wr_hit(dmom_pkg::A_TEACH) && wdata[2 * i] && !tn_ok[i]) ||
				(wr_hit(dmom_pkg::A_TEACH) && wdata[2 * i + 1] && !te_ok[i])) begin
				rej_set[0] = 1'b1;
			end
			if (wr_hit(dmom_pkg::A_CTRL) && !fn_ok[i]) begin
				rej_set[2] = 1'b1;
			end
		end
		rej_set[1] = wr_hit(dmom_pkg::A_CTRL) && !mode_ok;
	end

	// configuration registers, teach-in and curve copy
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			mode_r   <= dmom_pkg::MODE_ONE;
			inv_r    <= '0;
			nomlen_r <= dmom_pkg::NOMLEN_RST;
			for (int i = 0; i < 2; i++) begin
				func_r[i] <= dmom_pkg::FN_POS;
				null_r[i] <= '0;
				end_r[i]  <= dmom_pkg::END_RST_UM;
				lmin_r[i] <= dmom_pkg::LMIN_RST;
				lmax_r[i] <= dmom_pkg::LMAX_RST;
				errv_r[i] <= dmom_pkg::ERRV_RST;
			end
		end else begin
			if (wr_hit(dmom_pkg::A_CTRL) && mode_ok) begin
				mode_r <= mode_w;
			end
			if (wr_hit(dmom_pkg::A_NOMLEN)) begin
				nomlen_r <= wdata[15:0];
			end
			if (wr_hit(dmom_pkg::A_ERRV)) begin
				errv_r[0] <= wdata[15:0];
				errv_r[1] <= wdata[31:16];
			end
			for (int i = 0; i < 2; i++) begin
				// independent function per channel
				if (wr_hit(dmom_pkg::A_CTRL) && fn_ok[i]) begin
					func_r[i] <= fn_w[i];
				end
				if (wr_hit(dmom_pkg::A_CTRL)) begin
					inv_r[i] <= wdata[dmom_pkg::INV_LSB + i];
				end
				if (wr_hit(dmom_pkg::A_LIM[i])) begin
					lmin_r[i] <= wdata[15:0];
					lmax_r[i] <= wdata[31:16];
				end
				if (wr_hit(dmom_pkg::A_NULL[i]) && null_ok[i]) begin
					null_r[i] <= wdata[23:0];
				end
				if (wr_hit(dmom_pkg::A_END[i]) && end_ok[i]) begin
					end_r[i] <= wdata[23:0];
				end
				// teach-in takes the channel's current magnet
				if (wr_hit(dmom_pkg::A_TEACH) && wdata[2 * i] && tn_ok[i]) begin
					null_r[i] <= tpos[i];
				end
				if (wr_hit(dmom_pkg::A_TEACH) && wdata[2 * i + 1] && te_ok[i]) begin
					end_r[i] <= tpos[i];
				end
				// copy the other channel's curve, wins over same write
				if (wr_hit(dmom_pkg::A_CTRL) && wdata[dmom_pkg::COPY_LSB + i]) begin
					null_r[i] <= null_r[1 - i];
					end_r[i]  <= end_r[1 - i];
					inv_r[i]  <= inv_r[1 - i];
					lmin_r[i] <= lmin_r[1 - i];
					lmax_r[i] <= lmax_r[1 - i];
				end
			end
		end
	end

	// sticky refusal flags, a new refusal wins over the clear
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rej_r <= '0;
		end else if (wr_hit(dmom_pkg::A_STAT)) begin
			rej_r <= (rej_r & ~wdata[4:2]) | rej_set;
		end else begin
			rej_r <= rej_r | rej_set;
		end
	end

	logic [4:0]  us_cnt_r;    // cycle count within a microsecond
	logic        us_en;       // one-cycle microsecond enable
	logic [15:0] per1_us;     // single magnet period
	logic [15:0] per_us;      // active measurement period
	logic [15:0] spd_min_us;  // shortest speed window
	logic [15:0] meas_cnt_r;  // microseconds into the period
	logic        meas_tick_r; // period boundary pulse
	logic        start_r;     // computation start, one cycle later
	logic [15:0] spd_el_r;    // microseconds since speed update
	logic        spd_upd;     // speed update due at this tick

	// period from nominal length and magnet mode
	always_comb begin
		us_en   = us_cnt_r == dmom_pkg::US_LAST;
		per1_us = nomlen_r;
		if (nomlen_r < dmom_pkg::PER1_MIN_US) begin
			per1_us = dmom_pkg::PER1_MIN_US;
		end else if (nomlen_r > dmom_pkg::PER1_MAX_US) begin
			per1_us = dmom_pkg::PER1_MAX_US;
		end
		// two-magnet and flexible modes stretch the period by half
		per_us = (mode_r == dmom_pkg::MODE_ONE) ? per1_us : per1_us + (per1_us >> 1);
		spd_min_us = (mode_r == dmom_pkg::MODE_ONE) ? dmom_pkg::SPD1_US : dmom_pkg::SPD2_US;
		spd_upd    = spd_el_r >= spd_min_us;
	end

	// microsecond divider and period timer
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			us_cnt_r    <= '0;
			meas_cnt_r  <= '0;
			meas_tick_r <= 1'b0;
			start_r     <= 1'b0;
			spd_el_r    <= '0;
		end else begin
			us_cnt_r    <= us_en ? 5'h00 : us_cnt_r + 5'h01;
			meas_tick_r <= 1'b0;
			start_r     <= meas_tick_r;
			if (us_en) begin
				if (meas_cnt_r >= per_us - 16'h0001) begin
					meas_cnt_r  <= '0;
					meas_tick_r <= 1'b1;
				end else begin
					meas_cnt_r <= meas_cnt_r + 16'h0001;
				end
			end
			if (meas_tick_r && spd_upd) begin
				spd_el_r <= '0;
			end else if (us_en && spd_el_r != 16'hFFFF) begin
				spd_el_r <= spd_el_r + 16'h0001;
			end
		end
	end

	logic signed [24:0] dlt_r  [2]; // travel over the speed window
	logic [23:0]        prev_r [2]; // position at last speed update
	logic [15:0]        win_r;      // speed window in us

	// speed sampling, magnets 0 and 1 only so a third is ignored
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			win_r <= '0;
			for (int m = 0; m < 2; m++) begin
				dlt_r[m]  <= '0;
				prev_r[m] <= '0;
			end
		end else if (meas_tick_r && spd_upd) begin
			win_r     <= spd_el_r;
			dlt_r[0]  <= $signed({1'b0, samp_r.pos0}) - $signed({1'b0, prev_r[0]});
			dlt_r[1]  <= $signed({1'b0, samp_r.pos1}) - $signed({1'b0, prev_r[1]});
			prev_r[0] <= samp_r.pos0;
			prev_r[1] <= samp_r.pos1;
		end
	end

	logic [1:0]  fin_w;      // channel result ready
	logic [15:0] res_w [2];  // channel result code
	logic [1:0]  err_w;      // channel shows error value

	// per-channel scaling through a serial divider
	for (genvar i = 0; i < 2; i++) begin : g_ch
		dmom_pkg::dmom_dstate_t st_r;     // divider state
		logic [39:0]        q_r;          // dividend, then quotient
		logic [24:0]        rem_r;        // partial remainder
		logic [23:0]        den_r;        // divisor
		logic [5:0]         it_r;         // step count
		logic               neg_r;        // result negative
		logic               err_r;        // show error value
		logic               spd_r;        // speed function
		logic               msel;         // magnet for this channel
		logic [23:0]        x;            // input to the curve
		logic signed [24:0] v;            // signed distance or travel
		logic [23:0]        vmag;         // magnitude of v
		logic               rev;          // end below null
		logic               isspd;        // speed function selected
		logic               errc;         // error at start
		logic [24:0]        trial;        // shifted remainder
		logic [15:0]        qs;           // saturated quotient
		logic signed [17:0] s;            // signed code
		logic signed [17:0] lo;           // lower limit
		logic signed [17:0] hi;           // upper limit

		// select magnet, function and divisor
		always_comb begin
			// channel 2 follows magnet 2 unless single mode
			msel  = (i == 1) && (mode_r != dmom_pkg::MODE_ONE);
			x     = (func_r[i] == dmom_pkg::FN_DIFF) ? absd(samp_r.pos0, samp_r.pos1)
				: (msel ? samp_r.pos1 : samp_r.pos0);
			isspd = (func_r[i] == dmom_pkg::FN_SPD) || (func_r[i] == dmom_pkg::FN_SPDU);
			v     = isspd ? dlt_r[msel] : $signed({1'b0, x}) - $signed({1'b0, null_r[i]});
			vmag  = v[24] ? 24'(-v) : v[23:0];
			rev   = end_r[i] < null_r[i];
			case (mode_r)
				dmom_pkg::MODE_TWO: errc = samp_r.count < 2'h2;
				// flexible: one magnet feeds channel 1, channel 2 errors
				dmom_pkg::MODE_FLEX: errc = (i == 1) ? samp_r.count < 2'h2
					: samp_r.count == 2'h0;
				default: errc = samp_r.count == 2'h0;
			endcase
			if (func_r[i] == dmom_pkg::FN_DIFF && samp_r.count < 2'h2) begin
				errc = 1'b1;
			end
			trial = {rem_r[23:0], q_r[39]};
		end

		// restoring divider, one quotient bit per cycle
		always_ff @(posedge mclk or negedge nrst) begin
			if (!nrst) begin
				st_r  <= dmom_pkg::D_IDLE;
				q_r   <= '0;
				rem_r <= '0;
				den_r <= '0;
				it_r  <= '0;
				neg_r <= 1'b0;
				err_r <= 1'b0;
				spd_r <= 1'b0;
			end else begin
				case (st_r)
					dmom_pkg::D_IDLE: begin
						if (start_r) begin
							q_r   <= 40'(vmag) * 40'(dmom_pkg::OUT_FS);
							rem_r <= '0;
							it_r  <= '0;
							den_r <= isspd ? 24'({8'h00, win_r}) * dmom_pkg::SPD_UM_PER_US
								: absd(end_r[i], null_r[i]);
							// signed speed keeps direction, unsigned drops it
							neg_r <= isspd ? (func_r[i] == dmom_pkg::FN_SPD) && (v[24] ^ rev)
								: v[24] ^ rev;
							err_r <= errc;
							spd_r <= isspd;
							st_r  <= dmom_pkg::D_RUN;
						end
					end
					dmom_pkg::D_RUN: begin
						if (trial >= {1'b0, den_r}) begin
							rem_r <= trial - {1'b0, den_r};
							q_r   <= {q_r[38:0], 1'b1};
						end else begin
							rem_r <= trial;
							q_r   <= {q_r[38:0], 1'b0};
						end
						it_r <= it_r + 6'h01;
						if (it_r == dmom_pkg::DIV_LAST) begin
							st_r <= dmom_pkg::D_FIN;
						end
					end
					dmom_pkg::D_FIN: st_r <= dmom_pkg::D_IDLE;
					default: st_r <= dmom_pkg::D_IDLE;
				endcase
			end
		end

		// sign, inversion, limits and error value
		always_comb begin
			qs = (q_r > 40'(dmom_pkg::OUT_FS)) ? dmom_pkg::OUT_FS : q_r[15:0];
			s  = neg_r ? -$signed({2'b00, qs}) : $signed({2'b00, qs});
			if (inv_r[i]) begin
				s = spd_r ? -s : $signed({2'b00, dmom_pkg::OUT_FS}) - s;
			end
			lo = $signed({{2{lmin_r[i][15]}}, lmin_r[i]});
			hi = $signed({{2{lmax_r[i][15]}}, lmax_r[i]});
			if (s < lo) begin
				s = lo;
			end else if (s > hi) begin
				s = hi;
			end
			res_w[i] = err_r ? errv_r[i] : s[15:0];
			err_w[i] = err_r;
			fin_w[i] = st_r == dmom_pkg::D_FIN;
		end
	end

	// output stage registers, both channels finish together
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			ch_out <= '0;
		end else begin
			ch_out.strobe <= fin_w[0];
			if (fin_w[0]) begin
				ch_out.ch0    <= res_w[0];
				ch_out.err[0] <= err_w[0];
			end
			if (fin_w[1]) begin
				ch_out.ch1    <= res_w[1];
				ch_out.err[1] <= err_w[1];
			end
		end
	end

	// read data for one cycle after the read strobe
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rdata <= '0;
		end else begin
			rdata <= '0;
			if (rd_stb) begin
				case (addr)
					dmom_pkg::A_CTRL: rdata <= {22'h00_0000, inv_r, func_r[1], func_r[0], mode_r};
					dmom_pkg::A_NOMLEN: rdata <= {16'h0000, nomlen_r};
					dmom_pkg::A_NULL[0]: rdata <= {8'h00, null_r[0]};
					dmom_pkg::A_END[0]: rdata <= {8'h00, end_r[0]};
					dmom_pkg::A_NULL[1]: rdata <= {8'h00, null_r[1]};
					dmom_pkg::A_END[1]: rdata <= {8'h00, end_r[1]};
					dmom_pkg::A_LIM[0]: rdata <= {lmax_r[0], lmin_r[0]};
					dmom_pkg::A_LIM[1]: rdata <= {lmax_r[1], lmin_r[1]};
					dmom_pkg::A_ERRV: rdata <= {errv_r[1], errv_r[0]};
					dmom_pkg::A_STAT: rdata <= {27'h000_0000, rej_r, samp_r.count};
					dmom_pkg::A_OUT: rdata <= {ch_out.ch1, ch_out.ch0};
					default: rdata <= '0;
				endcase
			end
		end
	end
endmodule : dmom_core
`default_nettype wire

// [tb/dmom_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module dmom_monitor (
	input wire logic                mclk,
	input wire logic                nrst,
	input wire logic [5:0]          addr,
	input wire logic [31:0]         wdata,
	input wire logic                wr_stb,
	input wire logic                rd_stb,
	input wire logic [31:0]         rdata,
	input wire dmom_pkg::dmom_out_t ch_out
);
	logic [15:0] nomlen_r; // shadow of nominal length
	logic [31:0] lim0_r;   // shadow of channel 0 limits
	logic [31:0] lim1_r;   // shadow of channel 1 limits
	logic [31:0] errv_r;   // shadow of error values
	logic [7:0]  age_r;    // cycles since last write, saturating
	logic [17:0] gap_r;    // cycles since last update strobe

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	// shadows follow writes, copies move limits across
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			nomlen_r <= dmom_pkg::NOMLEN_RST;
			lim0_r   <= {dmom_pkg::LMAX_RST, dmom_pkg::LMIN_RST};
			lim1_r   <= {dmom_pkg::LMAX_RST, dmom_pkg::LMIN_RST};
			errv_r   <= {dmom_pkg::ERRV_RST, dmom_pkg::ERRV_RST};
		end else if (wr_stb) begin
			if (addr == dmom_pkg::A_NOMLEN) nomlen_r <= wdata[15:0];
			if (addr == dmom_pkg::A_ERRV) errv_r <= wdata;
			if (addr == dmom_pkg::A_LIM[0]) lim0_r <= wdata;
			else if (addr == dmom_pkg::A_CTRL && wdata[10]) lim0_r <= lim1_r;
			if (addr == dmom_pkg::A_LIM[1]) lim1_r <= wdata;
			else if (addr == dmom_pkg::A_CTRL && wdata[11]) lim1_r <= lim0_r;
		end
	end

	// age keeps in-flight updates out of the limit checks
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			age_r <= 8'h00;
			gap_r <= 18'h0_0000;
		end else begin
			age_r <= wr_stb ? 8'h00 : (age_r == 8'hFF ? age_r : age_r + 8'h01);
			gap_r <= ch_out.strobe ? 18'h0_0000 : gap_r + 18'h0_0001;
		end
	end

	a_rdata_idle: assert property (!$past(rd_stb) |-> rdata == 32'h0000_0000)
		else $error("read data not zero outside the answer cycle");
	a_strobe_pulse: assert property (ch_out.strobe |=> !ch_out.strobe)
		else $error("update strobe longer than one cycle");
	a_out_holds: assert property (!ch_out.strobe |-> $stable({ch_out.err, ch_out.ch1, ch_out.ch0}))
		else $error("outputs changed without strobe");
	a_period_bound: assert property (gap_r < 18'h2_9C3C)
		else $error("no update within the longest period");
	a_clamp_ch0: assert property (ch_out.strobe && !ch_out.err[0] && age_r > 8'h3C |->
		$signed(ch_out.ch0) >= $signed(lim0_r[15:0]) && $signed(ch_out.ch0) <= $signed(lim0_r[31:16]))
		else $error("channel 0 outside its limits");
	a_clamp_ch1: assert property (ch_out.strobe && !ch_out.err[1] && age_r > 8'h3C |->
		$signed(ch_out.ch1) >= $signed(lim1_r[15:0]) && $signed(ch_out.ch1) <= $signed(lim1_r[31:16]))
		else $error("channel 1 outside its limits");
	a_err_value: assert property (ch_out.strobe && age_r > 8'h3C |-> (!ch_out.err[0] ||
		ch_out.ch0 == errv_r[15:0]) && (!ch_out.err[1] || ch_out.ch1 == errv_r[31:16]))
		else $error("error flag without error value");
	a_err_pair: assert property (ch_out.err[0] |-> ch_out.err[1])
		else $error("channel 0 in error while channel 1 is not");
	a_two_refused: assert property (wr_stb && addr == dmom_pkg::A_CTRL && wdata[1:0] == dmom_pkg::MODE_TWO
		&& nomlen_r < dmom_pkg::MIN_TWO_LEN_MM ##[1:2] (rd_stb && addr == dmom_pkg::A_CTRL)
		|=> rdata[1:0] != dmom_pkg::MODE_TWO)
		else $error("two magnets accepted on a short sensor");
endmodule : dmom_monitor

bind dmom_core dmom_monitor dmom_monitor_inst (.mclk(mclk), .nrst(nrst), .addr(addr), .wdata(wdata),
	.wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .ch_out(ch_out));
`default_nettype wire

// [tb/dmom_host.sv]
`timescale 1ns/1ps
`default_nettype none
module dmom_host (
	input  wire logic                mclk,
	input  wire logic                nrst,
	input  wire dmom_pkg::dmom_out_t ch_out,
	output var  logic [15:0]         seen0,
	output var  logic [15:0]         seen1,
	output var  logic [1:0]          seen_err,
	output var  logic [31:0]         n_upd
);
	// host latches both channels together on each update strobe
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			seen0    <= 16'h0000;
			seen1    <= 16'h0000;
			seen_err <= 2'h0;
			n_upd    <= 32'h0000_0000;
		end else if (ch_out.strobe) begin
			seen0    <= ch_out.ch0;
			seen1    <= ch_out.ch1;
			seen_err <= ch_out.err;
			n_upd    <= n_upd + 32'h0000_0001;
		end
	end
endmodule : dmom_host
`default_nettype wire

// [tb/test_dual_magnet_output_mapper.sv]
`timescale 1ns/1ps
`default_nettype none
module test_dual_magnet_output_mapper;
	logic                mclk, nrst, wr_stb, rd_stb;
	logic [5:0]          addr;
	logic [31:0]         wdata, rdata, n_upd;
	dmom_pkg::dmom_fe_t  fe;       // front end sample
	dmom_pkg::dmom_out_t ch_out;
	logic [15:0]         seen0, seen1, scnt;
	logic [1:0]          seen_err, src_cnt;
	logic [23:0]         src_p0, src_p1; // resting magnet positions
	int                  step, mv, cyc, n_errors, checks;

	dmom_core dmom_core_inst (.mclk(mclk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
		.rd_stb(rd_stb), .rdata(rdata), .fe(fe), .ch_out(ch_out));
	dmom_host dmom_host_inst (.mclk(mclk), .nrst(nrst), .ch_out(ch_out), .seen0(seen0), .seen1(seen1),
		.seen_err(seen_err), .n_upd(n_upd));

	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	// front end: one sample every 25 us, magnets moving by step
	always @(posedge mclk) begin
		scnt <= (scnt == 16'h01F3) ? 16'h0000 : scnt + 16'h0001;
		fe.valid <= (scnt == 16'h01F3);
		if (scnt == 16'h01F3) begin
			mv <= mv + step;
			fe.count <= src_cnt;
			fe.pos0 <= src_p0 + 24'(mv);
			fe.pos1 <= src_p1 + 24'(mv);
		end
	end

	// hang guard
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 32'h0001_ADB0) begin
			n_errors++;
			give_verdict();
		end
	end

	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task wr(input logic [5:0] a, input logic [31:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge mclk);
		wr_stb <= 1'b0;
	endtask : wr

	// answer stands in the cycle after the strobe only
	task rd(input logic [5:0] a, input logic [31:0] exp, input string what);
		@(posedge mclk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge mclk);
		rd_stb <= 1'b0;
		#1;
		check(what, rdata, exp);
	endtask : rd

	task wait_upd(input int n);
		int tgt;
		int k;
		tgt = n_upd + n;
		k = 0;
		while (n_upd < tgt && k < n * 10000) begin
			@(posedge mclk);
			k++;
		end
		#1;
		check("update wait", {31'h0, n_upd >= tgt}, 32'h0000_0001);
	endtask : wait_upd

	task outs(input logic [1:0] e, input logic [15:0] c0, input logic [15:0] c1);
		check("err flags", {30'h0, seen_err}, {30'h0, e});
		check("ch0", {16'h0000, seen0}, {16'h0000, c0});
		check("ch1", {16'h0000, seen1}, {16'h0000, c1});
	endtask : outs

	function automatic logic in_rng(input logic signed [15:0] v, lo, hi);
		return v > lo && v < hi;
	endfunction : in_rng

	task give_verdict;
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : give_verdict

	initial begin
		nrst = 1'b0; addr = 6'h00; wdata = 32'h0000_0000; wr_stb = 1'b0; rd_stb = 1'b0; fe = '0;
		src_cnt = 2'h0; src_p0 = 24'h00_0000; src_p1 = 24'h00_0000; step = 0; mv = 0; scnt = 16'h0000;
		cyc = 0; n_errors = 0; checks = 0;
		repeat (3) @(posedge mclk);
		nrst <= 1'b1;
		rd(dmom_pkg::A_CTRL, 32'h0000_0001, "ctrl");
		rd(dmom_pkg::A_NOMLEN, 32'h0000_01F4, "nomlen");
		rd(dmom_pkg::A_END[0], 32'h0007_A120, "end0");
		rd(dmom_pkg::A_LIM[0], 32'h7FFF_8000, "lim0");
		rd(dmom_pkg::A_ERRV, 32'h7FFF_7FFF, "errv");
		rd(6'h30, 32'h0000_0000, "unmapped");
		$display("test reset done");
		// single mode, second magnet far away, ch0 inverted, ch1 clamped
		wr(dmom_pkg::A_NOMLEN, 32'h0000_00FA);
		src_cnt <= 2'h2; src_p0 <= 24'h03_D090; src_p1 <= 24'h00_2710;
		wr(dmom_pkg::A_LIM[1], 32'h1000_0100);
		wr(dmom_pkg::A_CTRL, 32'h0000_0101);
		wait_upd(2);
		outs(2'h0, 16'h4000, 16'h1000);
		wr(dmom_pkg::A_CTRL, 32'h0000_0901);
		rd(dmom_pkg::A_CTRL, 32'h0000_0301, "ctrl copy");
		rd(dmom_pkg::A_LIM[1], 32'h7FFF_8000, "lim1 copy");
		wr(dmom_pkg::A_CTRL, 32'h0000_0001);
		$display("test single done");
		// refused settings and teach-in
		wr(dmom_pkg::A_NULL[0], 32'h0007_9181);
		rd(dmom_pkg::A_NULL[0], 32'h0000_0000, "null0 close");
		wr(dmom_pkg::A_NOMLEN, 32'h0000_0050);
		wr(dmom_pkg::A_CTRL, 32'h0000_0002);
		rd(dmom_pkg::A_CTRL, 32'h0000_0001, "ctrl short");
		wr(dmom_pkg::A_CTRL, 32'h0000_000D);
		wr(dmom_pkg::A_CTRL, 32'h0000_0011);
		rd(dmom_pkg::A_CTRL, 32'h0000_0001, "ctrl func");
		rd(dmom_pkg::A_STAT, 32'h0000_001E, "stat");
		wr(dmom_pkg::A_STAT, 32'h0000_001C);
		rd(dmom_pkg::A_STAT, 32'h0000_0002, "stat clear");
		wr(dmom_pkg::A_NOMLEN, 32'h0000_00FA);
		wr(dmom_pkg::A_TEACH, 32'h0000_0001);
		rd(dmom_pkg::A_NULL[0], 32'h0003_D090, "null0 teach");
		wr(dmom_pkg::A_NULL[0], 32'h0000_0000);
		$display("test refusal done");
		// two magnets fixed
		wr(dmom_pkg::A_ERRV, 32'h0111_0222);
		wr(dmom_pkg::A_CTRL, 32'h0000_0002);
		src_cnt <= 2'h1;
		wait_upd(2);
		outs(2'h3, 16'h0222, 16'h0111);
		// changes made just after an update are all seen by the next one
		src_cnt <= 2'h3; src_p0 <= 24'h01_86A0; src_p1 <= 24'h06_1A80;
		wr(dmom_pkg::A_CTRL, 32'h0000_0062);
		rd(dmom_pkg::A_CTRL, 32'h0000_0062, "ctrl spacing");
		wait_upd(1);
		outs(2'h0, 16'h1999, 16'h4CCC);
		$display("test two done");
		// flexible mode
		wr(dmom_pkg::A_CTRL, 32'h0000_0003);
		src_cnt <= 2'h2;
		wait_upd(1);
		outs(2'h0, 16'h1999, 16'h6665);
		src_cnt <= 2'h1;
		wait_upd(1);
		outs(2'h2, 16'h1999, 16'h0111);
		rd(dmom_pkg::A_OUT, 32'h0111_1999, "out");
		$display("test flexible done");
		// speed: ch0 signed, ch1 magnitude, 2 um per us each way
		wr(dmom_pkg::A_CTRL, 32'h0000_0045);
		step <= 32'sh0000_0032;
		wait_upd(4);
		check("fwd speed", {31'h0, in_rng(seen0, 16'sh1770, 16'sh1C20)}, 32'h0000_0001);
		check("fwd magnitude", {31'h0, in_rng(seen1, 16'sh1770, 16'sh1C20)}, 32'h0000_0001);
		step <= -32'sh0000_0032;
		wait_upd(4);
		check("rev speed", {31'h0, in_rng(seen0, -16'sh1C20, -16'sh1770)}, 32'h0000_0001);
		check("rev magnitude", {31'h0, in_rng(seen1, 16'sh1770, 16'sh1C20)}, 32'h0000_0001);
		$display("test speed done");
		give_verdict();
	end
endmodule : test_dual_magnet_output_mapper
`default_nettype wire
